// ===== design/psi_pkg.sv
// Shared constants, types and helpers of the boot status indicator.
// Assumes one 25 MHz clock; all blink durations are counted in 0.25 s steps.
package psi_pkg;

    // Progress-code capture.
    localparam logic [15:0] POST_PORT_ADDR = 16'h0080;
    localparam logic [7:0]  CODE_RESET     = 8'h00;

    // Clock and pattern timing, times in milliseconds.
    localparam int unsigned CLK_HZ_DEF    = 25_000_000;
    localparam int unsigned STEP_MS       = 250;
    localparam int unsigned UPD_HALF_MS   = 500;
    localparam int unsigned BLINK_MS      = 1000;
    localparam int unsigned PAUSE_MS      = 2500;
    localparam int unsigned TONE_MS       = 1000;
    localparam int unsigned THERM_HALF_MS = 250;
    localparam int unsigned TONE_COUNT    = 8;
    localparam int unsigned VID_BLINKS    = 2;
    localparam int unsigned MEM_BLINKS    = 3;

    // Durations expressed in steps; the step counter is six bits wide.
    localparam logic [5:0] UPD_STEPS   = 6'(UPD_HALF_MS / STEP_MS);
    localparam logic [5:0] BLINK_STEPS = 6'(BLINK_MS / STEP_MS);
    localparam logic [5:0] PAUSE_STEPS = 6'(PAUSE_MS / STEP_MS);
    localparam logic [5:0] TONE_STEPS  = 6'(TONE_MS / STEP_MS);
    localparam logic [5:0] THERM_STEPS = 6'(THERM_HALF_MS / STEP_MS);
    localparam logic [5:0] UPD_PERIOD  = 6'(2 * UPD_STEPS);
    localparam logic [5:0] VID_LIT_END = 6'(2 * VID_BLINKS * BLINK_STEPS);
    localparam logic [5:0] VID_PERIOD  = 6'(VID_LIT_END + PAUSE_STEPS);
    localparam logic [5:0] MEM_LIT_END = 6'(2 * MEM_BLINKS * BLINK_STEPS);
    localparam logic [5:0] MEM_PERIOD  = 6'(MEM_LIT_END + PAUSE_STEPS);
    localparam logic [5:0] THERM_END   = 6'(TONE_COUNT * TONE_STEPS);

    // Range limits of the progress codes.
    localparam logic [7:0] CODE_SLEEP_HI  = 8'h05;
    localparam logic [7:0] CODE_RESUME_A  = 8'h10;
    localparam logic [7:0] CODE_RESUME_B  = 8'h20;
    localparam logic [7:0] CODE_RESUME_C  = 8'h30;
    localparam logic [7:0] CODE_PRE_LO    = 8'h11;
    localparam logic [7:0] CODE_PRE_HI    = 8'h1F;
    localparam logic [7:0] CODE_MEM_LO    = 8'h21;
    localparam logic [7:0] CODE_MEM_HI    = 8'h29;
    localparam logic [7:0] CODE_POST_LO   = 8'h2A;
    localparam logic [7:0] CODE_POST_HI   = 8'h2F;
    localparam logic [7:0] CODE_RCV_LO    = 8'h31;
    localparam logic [7:0] CODE_RCV_HI    = 8'h35;
    localparam logic [7:0] CODE_PLAT_LO   = 8'h36;
    localparam logic [7:0] CODE_PLAT_HI   = 8'h3F;
    localparam logic [7:0] CODE_CPU_LO    = 8'h41;
    localparam logic [7:0] CODE_CPU_HI    = 8'h4F;
    localparam logic [7:0] CODE_IO_LO     = 8'h50;
    localparam logic [7:0] CODE_IO_HI     = 8'h5F;
    localparam logic [7:0] CODE_IO_FATAL  = 8'h5F;
    localparam logic [7:0] CODE_SEL_LO    = 8'h60;
    localparam logic [7:0] CODE_SEL_HI    = 8'h6F;
    localparam logic [7:0] CODE_OUT_LO    = 8'h70;
    localparam logic [7:0] CODE_OUT_HI    = 8'h7F;
    localparam logic [7:0] CODE_RSV1_LO   = 8'h80;
    localparam logic [7:0] CODE_RSV1_HI   = 8'h8F;
    localparam logic [7:0] CODE_IN_LO     = 8'h90;
    localparam logic [7:0] CODE_IN_HI     = 8'h9F;
    localparam logic [7:0] CODE_RSV2_LO   = 8'hA0;
    localparam logic [7:0] CODE_RSV2_HI   = 8'hAF;
    localparam logic [7:0] CODE_MEDIA_LO  = 8'hB0;
    localparam logic [7:0] CODE_MEDIA_HI  = 8'hBF;
    localparam logic [7:0] CODE_RSV3_LO   = 8'hC0;
    localparam logic [7:0] CODE_RSV3_HI   = 8'hDF;

    typedef enum logic [3:0] {
        RNG_SLEEP_ENTRY = 4'b0000,
        RNG_RESUME      = 4'b0001,
        RNG_EARLY_PRE   = 4'b0010,
        RNG_MEM_DETECT  = 4'b0011,
        RNG_EARLY_POST  = 4'b0100,
        RNG_RECOVERY    = 4'b0101,
        RNG_PLATFORM    = 4'b0110,
        RNG_CPU_INIT    = 4'b0111,
        RNG_IO_BUS      = 4'b1000,
        RNG_BOOT_SELECT = 4'b1001,
        RNG_OUTPUT_CON  = 4'b1010,
        RNG_INPUT_DEV   = 4'b1011,
        RNG_BOOT_MEDIA  = 4'b1100,
        RNG_RESERVED    = 4'b1101,
        RNG_UNKNOWN     = 4'b1110
    } psi_range_t;

    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'b000,
        MODE_UPDATE   = 3'b001,
        MODE_VIDEO    = 3'b010,
        MODE_MEMORY   = 3'b011,
        MODE_THERMAL  = 3'b100,
        MODE_SHUTDOWN = 3'b101
    } psi_mode_t;

    // Indices of the synchronised fault inputs.
    localparam int unsigned SYNC_W      = 6;
    localparam int unsigned IX_UPDATE   = 0;
    localparam int unsigned IX_VIDEO    = 1;
    localparam int unsigned IX_NO_ROM   = 2;
    localparam int unsigned IX_VID_CFG  = 3;
    localparam int unsigned IX_MEMORY   = 4;
    localparam int unsigned IX_THERMAL  = 5;

    // Seven-segment pattern of one hex digit, segment a in bit 0, lit high.
    function automatic logic [6:0] psi_seg7(input logic [3:0] nib);
        logic [6:0] s;
        case (nib)
            4'h0: s = 7'h3F;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5B;
            4'h3: s = 7'h4F;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6D;
            4'h6: s = 7'h7D;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7F;
            4'h9: s = 7'h6F;
            4'hA: s = 7'h77;
            4'hB: s = 7'h7C;
            4'hC: s = 7'h39;
            4'hD: s = 7'h5E;
            4'hE: s = 7'h79;
            default: s = 7'h71;
        endcase
        return s;
    endfunction

endpackage

// ===== design/psi_tick.sv
// Divider that gives a one-cycle pulse every pattern step.
// Assumes a synchronous active-low reset on the one system clock.
`timescale 1ns/1ps
module psi_tick
    import psi_pkg::*;
#(
    parameter int unsigned TICK_CYC = 6_250_000
) (
    input  wire logic  ref_clk,
    input  wire logic  reset_n,
    psi_tick_if.gen    tk
);
    localparam int unsigned CW = $clog2(TICK_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tick_q;
    logic          tick_d;

    // A restart realigns the step grid to the start of a new pattern.
    always_comb begin
        cnt_d  = cnt_q + CW'(1);
        tick_d = 1'b0;
        if (tk.restart) begin
            cnt_d = '0;
        end else if (cnt_q == LAST) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule

// ===== design/psi_tick_if.sv
// Carries the step pulse and its restart between the pattern logic and its divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface psi_tick_if;
    logic restart;
    logic tick;
    modport gen (input restart, output tick);
    modport use_side (output restart, input tick);
endinterface

// ===== design/psi_top.sv
// Boot status indicator: progress-code capture, range decode and power LED patterns.
// Assumes I/O writes come from logic on ref_clk and fault requests from board pins.
`timescale 1ns/1ps
// Notes on behaviour
// - Faults replace steady LED with their blink pattern.
// - Update: dark first, then 0.5 s on/off.
// - Video: two 1 s blinks, 2.5 s dark, repeat.
// - Video pattern only when no display firmware.
// - Video indication off after reset until enabled.
// - Memory: three 1 s blinks, 2.5 s dark, repeat.
// - Thermal: 0.25 s blinks, two per tone, sixteen.
// - Eight alternating 1 s tones, then shut down.
// - Latch each code, hold last when writes stop.
// - Decode port writes, show code on segments.
// - Codes and limits handled as hexadecimal.
// - Codes 00 to 05 mean sleep-state entry.
// - Codes 10, 20, 30 mean resume.
// - 11-1F early pre-memory, 2A-2F early post-memory.
// - Codes 41 to 4F mean processor init.
// - 50-5F are I/O buses; 5F is fatal.
// - 60-6F boot select, 70-7F output consoles.
// - Codes B0 to BF mean boot media.
module psi_top
    import psi_pkg::*;
#(
    parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        io_wr,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        fw_update_active,
    input  wire logic        video_fault_req,
    input  wire logic        no_video_rom,
    input  wire logic        video_blink_en,
    input  wire logic        memory_fault_req,
    input  wire logic        thermal_trip_req,
    output logic [7:0]       post_code_q,
    output logic             code_valid_q,
    output psi_range_t       code_range_q,
    output logic             code_fatal_q,
    output logic [6:0]       seg_hi_q,
    output logic [6:0]       seg_lo_q,
    output logic             power_led_q,
    output logic             tone_active_q,
    output logic             tone_high_q,
    output logic             shutdown_q,
    output psi_mode_t        led_mode_q
);
    localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * STEP_MS;

    // Two-stage synchronisers for the pin-driven fault requests.
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;

    assign raw_in[IX_UPDATE]  = fw_update_active;
    assign raw_in[IX_VIDEO]   = video_fault_req;
    assign raw_in[IX_NO_ROM]  = no_video_rom;
    assign raw_in[IX_VID_CFG] = video_blink_en;
    assign raw_in[IX_MEMORY]  = memory_fault_req;
    assign raw_in[IX_THERMAL] = thermal_trip_req;

    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= raw_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    // Progress-code capture and range decode.
    function automatic psi_range_t classify(input logic [7:0] c);
        psi_range_t r;
        r = RNG_UNKNOWN;
        if (c <= CODE_SLEEP_HI) r = RNG_SLEEP_ENTRY;
        else if (c == CODE_RESUME_A || c == CODE_RESUME_B || c == CODE_RESUME_C)
            r = RNG_RESUME;
        else if (c >= CODE_PRE_LO && c <= CODE_PRE_HI) r = RNG_EARLY_PRE;
        else if (c >= CODE_MEM_LO && c <= CODE_MEM_HI) r = RNG_MEM_DETECT;
        else if (c >= CODE_POST_LO && c <= CODE_POST_HI) r = RNG_EARLY_POST;
        else if (c >= CODE_RCV_LO && c <= CODE_RCV_HI) r = RNG_RECOVERY;
        else if (c >= CODE_PLAT_LO && c <= CODE_PLAT_HI) r = RNG_PLATFORM;
        else if (c >= CODE_CPU_LO && c <= CODE_CPU_HI) r = RNG_CPU_INIT;
        else if (c >= CODE_IO_LO && c <= CODE_IO_HI) r = RNG_IO_BUS;
        else if (c >= CODE_SEL_LO && c <= CODE_SEL_HI) r = RNG_BOOT_SELECT;
        else if (c >= CODE_OUT_LO && c <= CODE_OUT_HI) r = RNG_OUTPUT_CON;
        else if (c >= CODE_IN_LO && c <= CODE_IN_HI) r = RNG_INPUT_DEV;
        else if (c >= CODE_MEDIA_LO && c <= CODE_MEDIA_HI) r = RNG_BOOT_MEDIA;
        else if ((c >= CODE_RSV1_LO && c <= CODE_RSV1_HI) ||
                 (c >= CODE_RSV2_LO && c <= CODE_RSV2_HI) ||
                 (c >= CODE_RSV3_LO && c <= CODE_RSV3_HI)) r = RNG_RESERVED;
        return r;
    endfunction

    logic       wr_hit;
    logic [7:0] code_d;
    logic       valid_d;
    psi_range_t range_d;
    logic       fatal_d;
    logic [6:0] seg_hi_d;
    logic [6:0] seg_lo_d;

    // The port decode takes the full 16-bit I/O address, so aliases are ignored.
    assign wr_hit = io_wr && (io_addr == POST_PORT_ADDR);

    always_comb begin
        code_d   = post_code_q;
        valid_d  = code_valid_q;
        range_d  = code_range_q;
        fatal_d  = code_fatal_q;
        seg_hi_d = seg_hi_q;
        seg_lo_d = seg_lo_q;
        if (wr_hit) begin
            code_d   = io_wdata;
            valid_d  = 1'b1;
            range_d  = classify(io_wdata);
            fatal_d  = (io_wdata == CODE_IO_FATAL);
            seg_hi_d = psi_seg7(io_wdata[7:4]);
            seg_lo_d = psi_seg7(io_wdata[3:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            post_code_q  <= CODE_RESET;
            code_valid_q <= 1'b0;
            code_range_q <= RNG_UNKNOWN;
            code_fatal_q <= 1'b0;
            seg_hi_q     <= 7'h00;
            seg_lo_q     <= 7'h00;
        end else begin
            post_code_q  <= code_d;
            code_valid_q <= valid_d;
            code_range_q <= range_d;
            code_fatal_q <= fatal_d;
            seg_hi_q     <= seg_hi_d;
            seg_lo_q     <= seg_lo_d;
        end
    end

    // Blink pattern sequencer.
    psi_tick_if tk ();

    psi_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .tk      (tk)
    );

    logic       upd_s;
    logic       vid_arm;
    logic       mem_s;
    logic       therm_s;
    psi_mode_t  mode_d;
    logic [5:0] pos_q;
    logic [5:0] pos_d;
    logic [5:0] period;
    logic       restart_d;
    logic       led_d;
    logic       tone_active_d;
    logic       tone_high_d;
    logic       shutdown_d;

    assign upd_s   = sync_q[IX_UPDATE];
    assign mem_s   = sync_q[IX_MEMORY];
    assign therm_s = sync_q[IX_THERMAL];
    assign vid_arm = sync_q[IX_VIDEO] && sync_q[IX_NO_ROM] && sync_q[IX_VID_CFG];

    always_comb begin
        case (led_mode_q)
            MODE_UPDATE:  period = UPD_PERIOD;
            MODE_VIDEO:   period = VID_PERIOD;
            MODE_MEMORY:  period = MEM_PERIOD;
            MODE_THERMAL: period = THERM_END;
            default:      period = 6'h01;
        endcase
    end

    // Thermal outranks memory, memory outranks video, video outranks update.
    always_comb begin
        mode_d    = led_mode_q;
        pos_d     = pos_q;
        restart_d = 1'b0;
        if (therm_s && led_mode_q != MODE_THERMAL && led_mode_q != MODE_SHUTDOWN) begin
            mode_d = MODE_THERMAL;
        end else if (mem_s && (led_mode_q == MODE_NORMAL || led_mode_q == MODE_UPDATE ||
                               led_mode_q == MODE_VIDEO)) begin
            mode_d = MODE_MEMORY;
        end else if (vid_arm && (led_mode_q == MODE_NORMAL || led_mode_q == MODE_UPDATE)) begin
            mode_d = MODE_VIDEO;
        end else if (upd_s && led_mode_q == MODE_NORMAL) begin
            mode_d = MODE_UPDATE;
        end else if (!upd_s && led_mode_q == MODE_UPDATE) begin
            mode_d = MODE_NORMAL;
        end else if (tk.tick && led_mode_q != MODE_NORMAL && led_mode_q != MODE_SHUTDOWN) begin
            if (pos_q == period - 6'h01) begin
                pos_d = 6'h00;
                if (led_mode_q == MODE_THERMAL) begin
                    mode_d = MODE_SHUTDOWN;
                end
            end else begin
                pos_d = pos_q + 6'h01;
            end
        end
        if (mode_d != led_mode_q) begin
            pos_d     = 6'h00;
            restart_d = 1'b1;
        end
    end

    always_comb begin
        led_d         = 1'b0;
        tone_active_d = 1'b0;
        tone_high_d   = 1'b0;
        shutdown_d    = 1'b0;
        case (mode_d)
            MODE_NORMAL:   led_d = 1'b1;
            MODE_UPDATE:   led_d = (pos_d >= UPD_STEPS);
            MODE_VIDEO:    led_d = (pos_d < VID_LIT_END) &&
                                   ((pos_d % (2 * BLINK_STEPS)) < BLINK_STEPS);
            MODE_MEMORY:   led_d = (pos_d < MEM_LIT_END) &&
                                   ((pos_d % (2 * BLINK_STEPS)) < BLINK_STEPS);
            MODE_THERMAL: begin
                led_d         = ((pos_d % (2 * THERM_STEPS)) < THERM_STEPS);
                tone_active_d = 1'b1;
                tone_high_d   = (((pos_d / TONE_STEPS) % 6'h02) == 6'h00);
            end
            MODE_SHUTDOWN: shutdown_d = 1'b1;
            default:       led_d = 1'b0;
        endcase
    end

    assign tk.restart = restart_d;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            led_mode_q    <= MODE_NORMAL;
            pos_q         <= 6'h00;
            power_led_q   <= 1'b1;
            tone_active_q <= 1'b0;
            tone_high_q   <= 1'b0;
            shutdown_q    <= 1'b0;
        end else begin
            led_mode_q    <= mode_d;
            pos_q         <= pos_d;
            power_led_q   <= led_d;
            tone_active_q <= tone_active_d;
            tone_high_q   <= tone_high_d;
            shutdown_q    <= shutdown_d;
        end
    end

    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_code_latch: assert property (wr_hit |=> post_code_q == $past(io_wdata))
        else $error("progress code not latched");
    a_code_hold: assert property (!wr_hit |=> $stable(post_code_q) && $stable(seg_lo_q))
        else $error("progress code changed without a write");
    a_seg_digits: assert property (code_valid_q |-> seg_hi_q == psi_seg7(post_code_q[7:4])
                                   && seg_lo_q == psi_seg7(post_code_q[3:0]))
        else $error("segments do not show the code");
    a_sleep_class: assert property (code_valid_q && post_code_q <= CODE_SLEEP_HI
                                    |-> code_range_q == RNG_SLEEP_ENTRY)
        else $error("sleep entry code misclassified");
    a_resume_class: assert property (code_valid_q && post_code_q == CODE_RESUME_B
                                     |-> code_range_q == RNG_RESUME)
        else $error("resume code misclassified");
    a_fatal_flag: assert property (code_valid_q
                                   |-> code_fatal_q == (post_code_q == CODE_IO_FATAL))
        else $error("fatal flag wrong");
    a_video_gate: assert property ($rose(led_mode_q == MODE_VIDEO)
                                   |-> $past(sync_q[IX_NO_ROM]))
        else $error("video pattern without missing display firmware");
    a_video_enable: assert property ($rose(led_mode_q == MODE_VIDEO)
                                     |-> $past(sync_q[IX_VID_CFG]))
        else $error("video pattern while disabled");
    a_update_dark: assert property ($rose(led_mode_q == MODE_UPDATE) |-> !power_led_q)
        else $error("update did not start dark");
    a_fault_lit: assert property ($rose(led_mode_q == MODE_MEMORY)
                                  |-> power_led_q ##1 power_led_q)
        else $error("fault pattern did not start lit");
    a_memory_sticky: assert property (led_mode_q == MODE_MEMORY
                                      |=> led_mode_q inside {MODE_MEMORY, MODE_THERMAL})
        else $error("memory pattern left before power off");
    a_thermal_blink: assert property (led_mode_q == MODE_THERMAL
                                      |-> power_led_q == !pos_q[0] && tone_active_q)
        else $error("thermal blink out of step");
    a_thermal_end: assert property (led_mode_q == MODE_THERMAL && tk.tick
                                    && pos_q == THERM_END - 6'h01
                                    |=> shutdown_q && !power_led_q)
        else $error("no shutdown after the last tone");

    c_memory: cover property (led_mode_q == MODE_MEMORY && pos_q == MEM_LIT_END);
    c_update: cover property (led_mode_q == MODE_UPDATE ##1 led_mode_q == MODE_NORMAL);
    c_shutdown: cover property ($rose(shutdown_q));
    c_fatal: cover property ($rose(code_fatal_q));
endmodule

// ===== verification/psi_host_model.sv
// Host-side model that writes progress codes over the one-cycle I/O strobe.
// Assumes it shares ref_clk with the indicator and is used only after reset.
`timescale 1ns/1ps
module psi_host_model (
    input  wire logic        ref_clk,
    output logic             io_wr,
    output logic [15:0]      io_addr,
    output logic [7:0]       io_wdata
);
    initial begin
        io_wr    = 1'b0;
        io_addr  = 16'h0000;
        io_wdata = 8'h00;
    end

    // After the strobe the lines are inverted so that no stale value is held.
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        io_wr    <= 1'b1;
        io_addr  <= a;
        io_wdata <= d;
        @(posedge ref_clk);
        io_wr    <= 1'b0;
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask
endmodule

// ===== verification/psi_top_tb_top.sv
// Self-checking bench of the boot status indicator: code capture, decode and LED patterns.
// Assumes a 250-cycle pattern step, obtained by running the indicator with CLK_HZ of 1000.
`timescale 1ns/1ps
module psi_top_tb_top
    import psi_pkg::*;
;
    localparam logic [6:0] SEG_TAB [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
        7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    // A 1 kHz clock setting gives 250 cycles per 0.25 s pattern step.
    localparam int STEP = 250;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        io_wr;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic [5:0]  pins = 6'h00;
    logic [7:0]  post_code_q, c, last;
    logic [15:0] a;
    logic        code_valid_q, code_fatal_q, power_led_q, tone_active_q, tone_high_q, shutdown_q;
    logic [6:0]  seg_hi_q, seg_lo_q;
    psi_range_t  code_range_q;
    psi_mode_t   led_mode_q;
    int          n_fail = 0;
    int          n_compared = 0;

    always #20 ref_clk = ~ref_clk;

    psi_host_model host (.ref_clk(ref_clk), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata));

    psi_top #(.CLK_HZ(1000)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .io_wr(io_wr),
        .io_addr(io_addr), .io_wdata(io_wdata), .fw_update_active(pins[0]),
        .video_fault_req(pins[1]), .no_video_rom(pins[2]), .video_blink_en(pins[3]),
        .memory_fault_req(pins[4]), .thermal_trip_req(pins[5]), .post_code_q(post_code_q),
        .code_valid_q(code_valid_q), .code_range_q(code_range_q), .code_fatal_q(code_fatal_q),
        .seg_hi_q(seg_hi_q), .seg_lo_q(seg_lo_q), .power_led_q(power_led_q),
        .tone_active_q(tone_active_q), .tone_high_q(tone_high_q), .shutdown_q(shutdown_q),
        .led_mode_q(led_mode_q));

    function automatic psi_range_t exp_rng(input logic [7:0] v);
        case (v) inside
            [8'h00:8'h05]: return RNG_SLEEP_ENTRY;
            8'h10, 8'h20, 8'h30: return RNG_RESUME;
            [8'h11:8'h1F]: return RNG_EARLY_PRE;
            [8'h21:8'h29]: return RNG_MEM_DETECT;
            [8'h2A:8'h2F]: return RNG_EARLY_POST;
            [8'h31:8'h35]: return RNG_RECOVERY;
            [8'h36:8'h3F]: return RNG_PLATFORM;
            [8'h41:8'h4F]: return RNG_CPU_INIT;
            [8'h50:8'h5F]: return RNG_IO_BUS;
            [8'h60:8'h6F]: return RNG_BOOT_SELECT;
            [8'h70:8'h7F]: return RNG_OUTPUT_CON;
            [8'h90:8'h9F]: return RNG_INPUT_DEV;
            [8'hB0:8'hBF]: return RNG_BOOT_MEDIA;
            [8'h80:8'h8F], [8'hA0:8'hAF], [8'hC0:8'hDF]: return RNG_RESERVED;
            default: return RNG_UNKNOWN;
        endcase
    endfunction

    // LED level expected in a given step of each pattern, counted from the mode change.
    function automatic logic exp_led(input psi_mode_t m, input int s);
        case (m)
            MODE_UPDATE: return (s % 4) >= 2;
            MODE_VIDEO:  return (s % 26) < 16 && ((s % 26) % 8) < 4;
            MODE_MEMORY: return (s % 34) < 24 && ((s % 34) % 8) < 4;
            default:     return (s % 2) == 0;
        endcase
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [5:0] p);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        pins    <= 6'h00;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        pins    <= p;
        @(negedge ref_clk);
    endtask

    // Waits for the mode, then samples the LED in the middle of each pattern step.
    task automatic watch(input psi_mode_t m, input int n);
        int k;
        k = 0;
        while (led_mode_q !== m && k < 20) begin
            @(negedge ref_clk);
            k++;
        end
        chk(led_mode_q, m);
        repeat (STEP / 2) @(negedge ref_clk);
        for (int s = 0; s < n; s++) begin
            chk(power_led_q, exp_led(m, s));
            if (m == MODE_THERMAL) chk({tone_active_q, tone_high_q}, {1'b1, ((s / 4) % 2) == 0});
            repeat (STEP) @(negedge ref_clk);
        end
        $display("pattern %0d done", m);
    endtask

    initial begin
        void'($urandom(65518));
        do_reset(6'h00);
        chk({post_code_q, code_valid_q, power_led_q}, 16'h0001);
        chk(code_range_q, RNG_UNKNOWN);
        last = 8'h00;
        for (int i = 0; i < 300; i++) begin
            c = (i < 256) ? 8'(i) : 8'($urandom);
            a = (i >= 256 && $urandom % 3 == 0) ? 16'($urandom | 1) : 16'h0080;
            host.put(a, c);
            if (a == 16'h0080) last = c;
            @(negedge ref_clk);
            chk(post_code_q, last);
            chk(code_range_q, exp_rng(last));
            chk(code_fatal_q, last == 8'h5F);
            chk({seg_hi_q, seg_lo_q}, {SEG_TAB[last[7:4]], SEG_TAB[last[3:0]]});
            chk(code_valid_q, 1'b1);
        end
        $display("code capture done");
        do_reset(6'h06);
        repeat (20) @(negedge ref_clk);
        chk({led_mode_q, power_led_q}, {MODE_NORMAL, 1'b1});
        @(posedge ref_clk) pins <= 6'h0A;
        repeat (20) @(negedge ref_clk);
        chk({led_mode_q, power_led_q}, {MODE_NORMAL, 1'b1});
        @(posedge ref_clk) pins <= 6'h0E;
        watch(MODE_VIDEO, 30);
        do_reset(6'h10);
        watch(MODE_MEMORY, 36);
        do_reset(6'h01);
        watch(MODE_UPDATE, 8);
        @(posedge ref_clk) pins <= 6'h00;
        repeat (10) @(negedge ref_clk);
        chk({led_mode_q, power_led_q}, {MODE_NORMAL, 1'b1});
        do_reset(6'h30);
        watch(MODE_THERMAL, 32);
        repeat (8) @(negedge ref_clk);
        chk({shutdown_q, power_led_q, tone_active_q}, 3'b100);
        test_done();
    end

    initial begin
        // The four patterns take about 110 steps; the span leaves ample margin.
        repeat (160 * STEP) @(posedge ref_clk);
        n_fail++;
        test_done();
    end
endmodule
